// [hw/pst_consts.svh]
// pst_consts.svh: offsets, field positions and reset values for the address translator
// assumes: included by bare name from the package and the design modules
`ifndef PST_CONSTS_SVH
`define PST_CONSTS_SVH

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define PST_WADDR_W      31
`define PST_OFF_W        10
`define PST_SEG_W        3
`define PST_SEG_LSB      28
`define PST_L1_LSB       19
`define PST_L2_LSB       10
`define PST_IDX_W        9
`define PST_PAGE_W       21
`define PST_SEG_N        8
`define PST_ENT_N        512

// ----------------------------------------------------------------
// translation entry fields
// ----------------------------------------------------------------
`define PST_TE_VALID     31
`define PST_TE_READ      30
`define PST_TE_WRITE     29
`define PST_TE_EXEC      28
`define PST_TE_PAGE_LSB  0

// ----------------------------------------------------------------
// segment base fields
// ----------------------------------------------------------------
`define PST_SB_VALID     31
`define PST_SB_TWOLVL    30
`define PST_SB_RING_LSB  27
`define PST_SB_PT_LSB    0
`define PST_SB_RESET     32'h00000000

`endif

// [hw/pst_pkg.sv]
// pst_pkg.sv: types shared by the address translator modules
// assumes: pst_consts.svh on the include path
`include "pst_consts.svh"
package pst_pkg;
	typedef enum logic [1:0] {PST_ACC_READ, PST_ACC_WRITE, PST_ACC_EXEC} pst_acc_t;
	typedef enum logic [2:0] {PST_OK, PST_FAULT_PAGE, PST_FAULT_SEG, PST_FAULT_PROT,
		PST_FAULT_RING} pst_fault_t;
	typedef enum {PST_IDLE, PST_WALK_TOP, PST_WALK_LEAF, PST_DONE} pst_state_t;
endpackage

// [hw/pst_entry_check.sv]
// pst_entry_check.sv: decodes one translation entry and checks it against an access
// assumes: purely combinational, used by the translator once per walk step
`timescale 1ns/10ps
`include "pst_consts.svh"
module pst_entry_check
	import pst_pkg::*;
(
	input  wire logic [31:0]               entry_in,   // raw translation entry
	input  wire logic [1:0]                acc_in,     // access kind
	input  wire logic                      leaf_in,    // entry maps a data page
	output logic      [`PST_PAGE_W-1:0]    page_out,   // physical page number
	output logic                           resid_out,  // page is resident
	output logic                           allow_out   // protocol permits the access
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// field split into page number and protocol bits
	always_comb begin
		page_out  = entry_in[`PST_TE_PAGE_LSB +: `PST_PAGE_W];
		resid_out = entry_in[`PST_TE_VALID];
		allow_out = 1'b1;
		// pointer entries of the upper level only need the valid bit
		if (leaf_in) begin
			unique case (acc_in)
				2'h0:    allow_out = entry_in[`PST_TE_READ];
				2'h1:    allow_out = entry_in[`PST_TE_WRITE];
				2'h2:    allow_out = entry_in[`PST_TE_EXEC];
				default: allow_out = 1'b0;
			endcase
		end
	end
endmodule

// [hw/pst_translator.sv]
// pst_translator.sv: paged segment address translator with table walk
// assumes: a memory port on the same clock answers each fetch with rdata_valid
`timescale 1ns/10ps
`include "pst_consts.svh"
module pst_translator
	import pst_pkg::*;
(
	input  wire logic                   clk_sys_in,      // 10 MHz system clock
	input  wire logic                   reset_n_in,      // synchronous reset, low active
	input  wire logic                   clk_en_in,       // freezes all state when low
	input  wire logic                   sbw_valid_in,    // write a segment base register
	input  wire logic [2:0]             sbw_seg_in,      // segment being written
	input  wire logic [31:0]            sbw_data_in,     // segment base value
	input  wire logic                   req_valid_in,    // logical reference request
	input  wire logic [31:0]            req_byte_addr_in,// logical byte address
	input  wire logic [1:0]             req_acc_in,      // access kind
	input  wire logic [2:0]             active_privilege_ring_in, // current ring
	output logic                        req_ready_out,   // idle, request taken
	output logic                        fetch_valid_out, // table fetch request
	output logic [31:0]                 fetch_addr_out,  // word address of entry
	input  wire logic                   fetch_ready_in,  // memory took fetch
	input  wire logic                   rdata_valid_in,  // entry returned
	input  wire logic [31:0]            rdata_in,        // returned entry
	output logic                        done_out,        // result pulse
	output logic [`PST_WADDR_W-1:0]     phys_waddr_out,  // physical word address
	output logic [2:0]                  fault_out        // fault code
);
	// ----------------------------------------------------------------
	// segment base registers
	// ----------------------------------------------------------------
	logic [31:0] segment_table_base_reg [`PST_SEG_N];
	logic [31:0] segment_table_base_next [`PST_SEG_N];

	// one register per segment, written from the core side
	genvar g;
	generate
		for (g = 0; g < `PST_SEG_N; g++) begin : g_sb
			always_comb begin
				segment_table_base_next[g] = segment_table_base_reg[g];
				if (sbw_valid_in && sbw_seg_in == 3'(g))
					segment_table_base_next[g] = sbw_data_in;
			end
			always_ff @(posedge clk_sys_in) begin
				if (!reset_n_in)
					segment_table_base_reg[g] <= `PST_SB_RESET;
				else if (clk_en_in)
					segment_table_base_reg[g] <= segment_table_base_next[g];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// walk state
	// ----------------------------------------------------------------
	pst_state_t                state_reg, state_next;
	logic [`PST_WADDR_W-1:0]   vaddr_reg, vaddr_next;
	logic [1:0]                acc_reg, acc_next;
	logic [2:0]                ring_reg, ring_next;
	logic                      issued_reg, issued_next;
	logic                      done_reg, done_next;
	logic [`PST_WADDR_W-1:0]   phys_reg, phys_next;
	logic [2:0]                fault_reg, fault_next;
	logic [`PST_PAGE_W-1:0]    ent_page;
	logic                      ent_resid;
	logic                      ent_allow;
	logic [31:0]               cur_base;
	logic [2:0]                cur_seg;

	// byte address bit 0 drops to make a 31-bit word address
	function automatic logic [`PST_WADDR_W-1:0] word_addr(input logic [31:0] b);
		return b[31:1];
	endfunction

	// entry fetch address: table page start plus index, doubleword per entry
	function automatic logic [31:0] entry_addr(input logic [`PST_PAGE_W-1:0] pg,
		input logic [`PST_IDX_W-1:0] idx);
		return {1'b0, pg, `PST_OFF_W'(0)} | {22'h000000, idx, 1'b0};
	endfunction

	assign cur_seg  = vaddr_reg[`PST_SEG_LSB +: `PST_SEG_W];
	assign cur_base = segment_table_base_reg[cur_seg];

	pst_entry_check u_check (
		.entry_in  (rdata_in),
		.acc_in    (acc_reg),
		.leaf_in   (state_reg == PST_WALK_LEAF),
		.page_out  (ent_page),
		.resid_out (ent_resid),
		.allow_out (ent_allow)
	);

	// walk sequencing, checks and address formation
	always_comb begin
		state_next  = state_reg;
		vaddr_next  = vaddr_reg;
		acc_next    = acc_reg;
		ring_next   = ring_reg;
		issued_next = issued_reg;
		done_next   = 1'b0;
		phys_next   = phys_reg;
		fault_next  = fault_reg;
		unique case (state_reg)
			PST_IDLE: begin
				if (req_valid_in) begin
					vaddr_next  = word_addr(req_byte_addr_in);
					acc_next    = req_acc_in;
					ring_next   = active_privilege_ring_in;
					issued_next = 1'b0;
					state_next  = PST_WALK_TOP;
				end
			end
			PST_WALK_TOP: begin
				// ring 0 is most privileged; outer rings may not reach inward
				if (!cur_base[`PST_SB_VALID]) begin
					fault_next = 3'(PST_FAULT_SEG);
					state_next = PST_DONE;
				end else if (ring_reg > cur_base[`PST_SB_RING_LSB +: 3]) begin
					fault_next = 3'(PST_FAULT_RING);
					state_next = PST_DONE;
				end else if (!cur_base[`PST_SB_TWOLVL]) begin
					state_next  = PST_WALK_LEAF;
					issued_next = 1'b0;
				end else if (fetch_ready_in && !issued_reg) begin
					issued_next = 1'b1;
				end else if (issued_reg && rdata_valid_in) begin
					issued_next = 1'b0;
					if (!ent_resid) begin
						fault_next = 3'(PST_FAULT_PAGE);
						state_next = PST_DONE;
					end else begin
						state_next = PST_WALK_LEAF;
					end
				end
			end
			PST_WALK_LEAF: begin
				if (fetch_ready_in && !issued_reg)
					issued_next = 1'b1;
				else if (issued_reg && rdata_valid_in) begin
					issued_next = 1'b0;
					state_next  = PST_DONE;
					if (!ent_resid)
						fault_next = 3'(PST_FAULT_PAGE);
					else if (!ent_allow)
						fault_next = 3'(PST_FAULT_PROT);
					else begin
						fault_next = 3'(PST_OK);
						// whole page number kept so the word address fills all 31 bits
						phys_next  = {ent_page, vaddr_reg[`PST_OFF_W-1:0]};
					end
				end
			end
			PST_DONE: begin
				done_next  = 1'b1;
				state_next = PST_IDLE;
			end
		endcase
	end

	// the leaf table base comes from the segment or from the top-level entry
	logic [`PST_PAGE_W-1:0] leaf_pg_reg, leaf_pg_next;
	always_comb begin
		leaf_pg_next = leaf_pg_reg;
		if (state_reg == PST_WALK_TOP && state_next == PST_WALK_LEAF)
			leaf_pg_next = cur_base[`PST_SB_TWOLVL] ? ent_page
				: cur_base[`PST_SB_PT_LSB +: `PST_PAGE_W];
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state_reg   <= PST_IDLE;
			vaddr_reg   <= '0;
			acc_reg     <= 2'h0;
			ring_reg    <= 3'h0;
			issued_reg  <= 1'b0;
			done_reg    <= 1'b0;
			phys_reg    <= '0;
			fault_reg   <= 3'h0;
			leaf_pg_reg <= '0;
		end else if (clk_en_in) begin
			state_reg   <= state_next;
			vaddr_reg   <= vaddr_next;
			acc_reg     <= acc_next;
			ring_reg    <= ring_next;
			issued_reg  <= issued_next;
			done_reg    <= done_next;
			phys_reg    <= phys_next;
			fault_reg   <= fault_next;
			leaf_pg_reg <= leaf_pg_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// fetch held until taken; a two-level top index uses address bits 27:19
	assign req_ready_out   = (state_reg == PST_IDLE);
	assign fetch_valid_out = !issued_reg && ((state_reg == PST_WALK_LEAF) ||
		(state_reg == PST_WALK_TOP && cur_base[`PST_SB_VALID] && cur_base[`PST_SB_TWOLVL]
		&& !(ring_reg > cur_base[`PST_SB_RING_LSB +: 3])));
	assign fetch_addr_out  = (state_reg == PST_WALK_LEAF)
		? entry_addr(leaf_pg_reg, vaddr_reg[`PST_L2_LSB +: `PST_IDX_W])
		: entry_addr(cur_base[`PST_SB_PT_LSB +: `PST_PAGE_W],
			vaddr_reg[`PST_L1_LSB +: `PST_IDX_W]);
	assign done_out        = done_reg;
	assign phys_waddr_out  = phys_reg;
	assign fault_out       = fault_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	a_ok_offset_kept: assert property ((done_out && fault_out == 3'h0) |->
		phys_waddr_out[`PST_OFF_W-1:0] == vaddr_reg[`PST_OFF_W-1:0])
		else $error("offset not carried to physical address");
	a_fetch_aligned: assert property (fetch_valid_out |-> fetch_addr_out[0] == 1'b0)
		else $error("entry fetch not doubleword aligned");
	a_ring_fault: assert property ((state_reg == PST_WALK_TOP && clk_en_in &&
		cur_base[`PST_SB_VALID] && ring_reg > cur_base[`PST_SB_RING_LSB +: 3])
		|=> ##1 (done_out && fault_out == 3'h4))
		else $error("ring violation not faulted");
	a_page_fault: assert property ((state_reg == PST_WALK_LEAF && issued_reg &&
		rdata_valid_in && clk_en_in && !rdata_in[`PST_TE_VALID])
		|=> ##1 (done_out && fault_out == 3'h1))
		else $error("non-resident page not faulted");
	a_write_prot: assert property ((state_reg == PST_WALK_LEAF && issued_reg &&
		rdata_valid_in && clk_en_in && acc_reg == 2'h1 && rdata_in[`PST_TE_VALID]
		&& !rdata_in[`PST_TE_WRITE]) |=> ##1 (done_out && fault_out == 3'h3))
		else $error("write to protected page not faulted");
	a_sbr_write: assert property ((sbw_valid_in && clk_en_in) |=>
		segment_table_base_reg[$past(sbw_seg_in)] == $past(sbw_data_in))
		else $error("segment base register not written");
	a_one_level: assert property ((state_reg == PST_WALK_TOP && clk_en_in &&
		cur_base[`PST_SB_VALID] && !cur_base[`PST_SB_TWOLVL] &&
		!(ring_reg > cur_base[`PST_SB_RING_LSB +: 3])) |=> state_reg == PST_WALK_LEAF)
		else $error("one-level table did not go to leaf");
	a_leaf_index: assert property ((fetch_valid_out && state_reg == PST_WALK_LEAF)
		|-> fetch_addr_out[`PST_OFF_W-1:1] == vaddr_reg[`PST_L2_LSB +: `PST_IDX_W])
		else $error("leaf entry index wrong");
endmodule

// [test/pst_mem_model.sv]
// pst_mem_model.sv: behavioural physical memory that answers table fetches
// assumes: same clock as the translator; the bench loads entries with put
`timescale 1ns/10ps
module pst_mem_model (
	input  wire logic        clk_sys_in,      // system clock
	input  wire logic        fetch_valid_in,  // fetch request
	input  wire logic [31:0] fetch_addr_in,   // entry word address
	input  wire logic [1:0]  lat_in,          // extra answer delay in cycles
	output logic             fetch_ready_out, // fetch taken
	output logic             rdata_valid_out, // entry returned
	output logic [31:0]      rdata_out        // entry, scrambled when idle
);
	logic [31:0] mem [int];
	logic [31:0] addr_reg;
	logic [1:0]  wait_reg;
	logic        pend_reg;
	int          fetch_count;
	initial begin
		fetch_ready_out = 1'b0;
		rdata_valid_out = 1'b0;
		rdata_out = 32'h0;
		pend_reg = 1'b0;
		fetch_count = 0;
	end
	task put(input logic [31:0] a, input logic [31:0] d);
		mem[a] = d;
	endtask
	// ----------------------------------------------------------------
	// fetch handshake, one fetch in flight
	// ----------------------------------------------------------------
	// data lines invert every idle cycle so a stale entry is never mistaken for an answer
	always @(posedge clk_sys_in) begin
		rdata_valid_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (fetch_valid_in && fetch_ready_out) begin
			pend_reg <= 1'b1;
			addr_reg <= fetch_addr_in;
			wait_reg <= lat_in;
			fetch_ready_out <= 1'b0;
			fetch_count <= fetch_count + 1;
		end else if (pend_reg) begin
			if (wait_reg == 2'h0) begin
				rdata_valid_out <= 1'b1;
				rdata_out <= mem.exists(addr_reg) ? mem[addr_reg] : 32'h0;
				pend_reg <= 1'b0;
			end else begin
				wait_reg <= wait_reg - 2'h1;
			end
		end else begin
			fetch_ready_out <= fetch_valid_in;
		end
	end
endmodule

// [test/pst_translator_bench.sv]
// pst_translator_bench.sv: self-checking bench for the address translator
// assumes: pst_mem_model answers fetches; inputs change on falling edges
`timescale 1ns/10ps
module pst_translator_bench;
	import pst_pkg::*;
	typedef struct packed {
		logic [2:0]  seg;
		logic [8:0]  top;
		logic [8:0]  leaf;
		logic [9:0]  off;
		logic [1:0]  acc;
		logic [2:0]  ring;
		logic [2:0]  fault;
		logic [20:0] page;
		logic [1:0]  nf;
	} pst_row_t;
	logic        clk_sys, reset_n, clk_en, sbw_valid, req_valid, req_ready;
	logic        fetch_valid, fetch_ready, rdata_valid, done;
	logic [2:0]  sbw_seg, ring, fault;
	logic [31:0] sbw_data, req_addr, fetch_addr, rdata;
	logic [1:0]  acc, lat;
	logic [30:0] phys;
	int          bad_count, tests_run, nf0;
	bit          hit;
	// ----------------------------------------------------------------
	// ordinary cases: one-level seg 1, two-level seg 2, empty seg 3
	// ----------------------------------------------------------------
	// nf 3 means the fetch count is left open
	pst_row_t rows [12] = '{
		'{3'h1, 9'h000, 9'h001, 10'h3FF, 2'h0, 3'h0, 3'h0, 21'h12345, 2'h1},
		'{3'h1, 9'h000, 9'h002, 10'h000, 2'h1, 3'h2, 3'h0, 21'h00111, 2'h1},
		'{3'h1, 9'h000, 9'h003, 10'h155, 2'h2, 3'h7, 3'h0, 21'h00222, 2'h1},
		'{3'h1, 9'h000, 9'h004, 10'h000, 2'h1, 3'h0, 3'h3, 21'h00000, 2'h1},
		'{3'h1, 9'h000, 9'h005, 10'h000, 2'h0, 3'h0, 3'h1, 21'h00000, 2'h1},
		'{3'h1, 9'h000, 9'h1FF, 10'h3FF, 2'h0, 3'h0, 3'h0, 21'hFFFFF, 2'h1},
		'{3'h1, 9'h000, 9'h001, 10'h000, 2'h3, 3'h0, 3'h3, 21'h00000, 2'h3},
		'{3'h3, 9'h000, 9'h001, 10'h000, 2'h0, 3'h0, 3'h2, 21'h00000, 2'h3},
		'{3'h2, 9'h005, 9'h1FF, 10'h2AA, 2'h0, 3'h3, 3'h0, 21'h54321, 2'h2},
		'{3'h2, 9'h005, 9'h1FF, 10'h000, 2'h0, 3'h4, 3'h4, 21'h00000, 2'h3},
		'{3'h2, 9'h006, 9'h1FF, 10'h000, 2'h0, 3'h0, 3'h1, 21'h00000, 2'h1},
		'{3'h2, 9'h005, 9'h1FF, 10'h001, 2'h2, 3'h0, 3'h3, 21'h00000, 2'h2}};
	always #50 clk_sys = ~clk_sys;
	pst_translator i_dut (
		.clk_sys_in(clk_sys), .reset_n_in(reset_n), .clk_en_in(clk_en),
		.sbw_valid_in(sbw_valid), .sbw_seg_in(sbw_seg), .sbw_data_in(sbw_data),
		.req_valid_in(req_valid), .req_byte_addr_in(req_addr), .req_acc_in(acc),
		.active_privilege_ring_in(ring), .req_ready_out(req_ready),
		.fetch_valid_out(fetch_valid), .fetch_addr_out(fetch_addr),
		.fetch_ready_in(fetch_ready), .rdata_valid_in(rdata_valid), .rdata_in(rdata),
		.done_out(done), .phys_waddr_out(phys), .fault_out(fault));
	pst_mem_model i_mem (
		.clk_sys_in(clk_sys), .fetch_valid_in(fetch_valid), .fetch_addr_in(fetch_addr),
		.lat_in(lat), .fetch_ready_out(fetch_ready), .rdata_valid_out(rdata_valid),
		.rdata_out(rdata));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task write_sb(input logic [2:0] s, input logic [31:0] d);
		@(negedge clk_sys);
		sbw_valid = 1'b1;
		sbw_seg = s;
		sbw_data = d;
		@(negedge clk_sys);
		sbw_valid = 1'b0;
	endtask
	// bounded wait for the result pulse, sampled mid-cycle
	task wait_done;
		hit = 1'b0;
		for (int k = 0; k < 40 && !hit; k++) begin
			@(negedge clk_sys);
			if (done === 1'b1)
				hit = 1'b1;
		end
	endtask
	task issue(input pst_row_t r);
		@(negedge clk_sys);
		req_addr = {r.seg, r.top, r.leaf, r.off, 1'b0};
		acc = r.acc;
		ring = r.ring;
		req_valid = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
		wait_done();
	endtask
	initial begin
		repeat (3000) @(posedge clk_sys);
		bad_count++;
		print_verdict();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{clk_sys, reset_n, sbw_valid, req_valid, sbw_seg, sbw_data, req_addr} = '0;
		{clk_en, acc, ring, lat, bad_count, tests_run} = '0;
		clk_en = 1'b1;
		repeat (2) @(negedge clk_sys);
		check({26'h0, req_ready, fetch_valid, done, fault}, 32'h20);
		reset_n = 1'b1;
		// entries: seg 1 table at page 40, seg 2 top at 80 pointing to page C0
		i_mem.put(32'h10002, 32'hC0012345);
		i_mem.put(32'h10004, 32'hA0000111);
		i_mem.put(32'h10006, 32'h90000222);
		i_mem.put(32'h10008, 32'hC0000333);
		i_mem.put(32'h1000A, 32'h70000444);
		i_mem.put(32'h103FE, 32'hF00FFFFF);
		i_mem.put(32'h2000A, 32'h800000C0);
		i_mem.put(32'h2000C, 32'h000000C0);
		i_mem.put(32'h303FE, 32'hC0054321);
		write_sb(3'h1, 32'hB8000040);
		write_sb(3'h2, 32'hD8000080);
		foreach (rows[i]) begin
			lat = 2'(i % 3);
			nf0 = i_mem.fetch_count;
			issue(rows[i]);
			check({31'h0, hit}, 32'h1);
			check({29'h0, fault}, {29'h0, rows[i].fault});
			if (rows[i].fault == 3'h0)
				check({1'b0, phys}, {1'b0, rows[i].page, rows[i].off});
			if (rows[i].nf != 2'h3)
				check(i_mem.fetch_count - nf0, {30'h0, rows[i].nf});
		end
		// reset in mid-run clears every base register
		@(negedge clk_sys);
		reset_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		// the last row left a protection fault standing; reset must clear it
		check({26'h0, req_ready, fetch_valid, done, fault}, 32'h20);
		reset_n = 1'b1;
		issue(rows[0]);
		check({31'h0, hit}, 32'h1);
		check({29'h0, fault}, 32'h2);
		// frozen clock enable holds a request back until released
		write_sb(3'h1, 32'hB8000040);
		clk_en = 1'b0;
		req_addr = {rows[0].seg, rows[0].top, rows[0].leaf, rows[0].off, 1'b0};
		acc = 2'h0;
		req_valid = 1'b1;
		repeat (4) @(negedge clk_sys);
		check({31'h0, done}, 32'h0);
		// a request taken while frozen would have dropped ready already
		check({31'h0, req_ready}, 32'h1);
		clk_en = 1'b1;
		@(negedge clk_sys);
		req_valid = 1'b0;
		wait_done();
		check({31'h0, hit}, 32'h1);
		check({29'h0, fault}, 32'h0);
		check({1'b0, phys}, {1'b0, 21'h12345, 10'h3FF});
		print_verdict();
	end
endmodule
